// [rtl/qos_sched_pkg.sv]
// Constants and carrier types of the layer 3 QoS bandwidth scheduler
package qos_sched_pkg;
	localparam int NUM_RULES = 32;
	localparam int QW = 6;
	localparam int RATE_W = 16;
	localparam int OCC_W = 16;
	localparam int KEY_W = 6;
	localparam logic [11:0] ADR_MODE = 12'h000;
	localparam logic [11:0] ADR_STATUS = 12'h004;
	localparam logic [11:0] ADR_DROPS = 12'h008;
	localparam logic [11:0] ADR_RULE_BASE = 12'h100;
	localparam logic [1:0] FLD_CFG = 2'h0;
	localparam logic [1:0] FLD_MIN = 2'h1;
	localparam logic [1:0] FLD_MAX = 2'h2;
	localparam logic [1:0] FLD_OCC = 2'h3;
	localparam int CFG_PRIO_LSB = 0;
	localparam int CFG_WRED_BIT = 4;
	localparam int CFG_FILT_BIT = 5;
	localparam logic [3:0] PRIO_RST = 4'h1;
	localparam logic [RATE_W-1:0] MIN_RST = 16'h0000;
	localparam logic [RATE_W-1:0] MAX_RST = 16'hffff;
	localparam logic [3:0] PRIO_MM_RULE = 4'h8;
	localparam logic [3:0] PRIO_MM_DEF = 4'h9;
	localparam logic [3:0] PRIO_ASSURED = 4'h7;
	localparam int DS_QUEUES = 11;
	localparam logic [QW-1:0] DS_BE_Q = 6'h0a;
	localparam logic [QW-1:0] DS_AF_FIRST = 6'h06;
	localparam logic [QW-1:0] DS_AF_LAST = 6'h09;
	localparam logic [3:0] DS_PRIO [DS_QUEUES] = '{4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5,
		4'h7, 4'h7, 4'h7, 4'h7, 4'h8};
	localparam int CLK_PERIOD_NS = 4;
	localparam int EPOCH_TIME_NS = 1000;
	localparam int EPOCH_CYCLES = EPOCH_TIME_NS / CLK_PERIOD_NS;
	localparam int LFSR_W = 16;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
	typedef enum logic [1:0] {MODE_MAXPRI, MODE_MINMAX, MODE_DIFFSERV} mode_type;
	typedef struct packed {
		logic [QW-1:0] rule;
		logic [5:0] dscp;
		logic [OCC_W-1:0] len;
	} pkt_in_type;
	typedef struct packed {
		logic [QW-1:0] queue;
	} grant_type;
endpackage

// [rtl/qos_scheduler.sv]
// Layer 3 QoS scheduler: queue accounting, drop policy, rate-credited arbiter
`timescale 1ns/100ps
module qos_scheduler #(
	parameter int NUM_RULES = qos_sched_pkg::NUM_RULES,
	parameter int QUEUE_CAP = 4096
) (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pkt_valid_i,
	input wire qos_sched_pkg::pkt_in_type pkt_i,
	output logic pkt_ready_o,
	output logic pkt_drop_o,
	input wire logic [qos_sched_pkg::RATE_W-1:0] link_rate_i,
	input wire logic link_ready_i,
	output logic grant_valid_o,
	output qos_sched_pkg::grant_type grant_o
);
	localparam int NQ = NUM_RULES + 1;
	localparam int QW = qos_sched_pkg::QW;
	localparam int RW = qos_sched_pkg::RATE_W;
	localparam int OW = qos_sched_pkg::OCC_W;
	localparam int KW = qos_sched_pkg::KEY_W;
	localparam logic [QW-1:0] DEF_Q = QW'(NUM_RULES);
	localparam logic [OW:0] CAP = (OW+1)'(QUEUE_CAP);
	localparam logic [OW:0] HALF = (OW+1)'(QUEUE_CAP / 2);

	if (NUM_RULES < qos_sched_pkg::DS_QUEUES
		|| NUM_RULES > qos_sched_pkg::NUM_RULES) begin : g_bad_rules
		$error("NUM_RULES out of range");
	end
	if (QUEUE_CAP < 2 || QUEUE_CAP >= (1 << OW)) begin : g_bad_cap
		$error("QUEUE_CAP out of range");
	end

	qos_sched_pkg::mode_type mode_r;
	logic [3:0] prio_r [NQ];
	logic wred_r [NQ];
	logic filt_r [NQ];
	logic [RW-1:0] min_r [NQ];
	logic [RW-1:0] max_r [NQ];
	logic [OW-1:0] occ_r [NQ];
	logic [RW-1:0] min_cred_r [NQ];
	logic [RW-1:0] max_cred_r [NQ];
	logic [RW-1:0] budget_r;
	logic [RW-1:0] rate_prev_r;
	logic [15:0] epoch_r;
	logic [31:0] drops_r;
	logic [qos_sched_pkg::LFSR_W-1:0] lfsr_r;
	logic [QW-1:0] rr_r;
	logic cfg_chg_r;

	function automatic logic [QW-1:0] ds_queue(input logic [5:0] cp);
		casez (cp)
			6'b111000: ds_queue = 6'h00;
			6'b110000: ds_queue = 6'h01;
			6'b101110: ds_queue = 6'h02;
			6'b101000: ds_queue = 6'h03;
			6'b100000: ds_queue = 6'h04;
			6'b011000: ds_queue = 6'h05;
			6'b100??0: ds_queue = 6'h06;
			6'b011??0: ds_queue = 6'h07;
			6'b010??0: ds_queue = 6'h08;
			6'b001??0: ds_queue = 6'h09;
			default: ds_queue = qos_sched_pkg::DS_BE_Q;
		endcase
	endfunction

	// Effective per-queue settings; DiffServ overrides user fields
	logic [3:0] eprio [NQ];
	logic ewred [NQ];
	logic efilt [NQ];
	logic [KW-1:0] key [NQ];
	logic elig [NQ];
	always_comb begin
		for (int q = 0; q < NQ; q++) begin
			eprio[q] = prio_r[q];
			ewred[q] = wred_r[q];
			efilt[q] = filt_r[q];
			key[q] = {prio_r[q], 2'b00};
			elig[q] = occ_r[q] != '0;
			unique case (mode_r)
				qos_sched_pkg::MODE_MAXPRI: begin
					elig[q] = occ_r[q] != '0 && max_cred_r[q] != '0;
				end
				qos_sched_pkg::MODE_MINMAX: begin
					eprio[q] = (q == NUM_RULES) ? qos_sched_pkg::PRIO_MM_DEF
						: qos_sched_pkg::PRIO_MM_RULE;
					key[q] = {eprio[q], 1'b0, min_cred_r[q] == '0};
					if (q != NUM_RULES)
						elig[q] = occ_r[q] != '0 && max_cred_r[q] != '0;
				end
				qos_sched_pkg::MODE_DIFFSERV: begin
					eprio[q] = (q < qos_sched_pkg::DS_QUEUES)
						? qos_sched_pkg::DS_PRIO[q % qos_sched_pkg::DS_QUEUES] : 4'hf;
					ewred[q] = 1'b1;
					efilt[q] = 1'b0;
					key[q] = {eprio[q], 1'b0, min_cred_r[q] == '0};
					elig[q] = occ_r[q] != '0 && q < qos_sched_pkg::DS_QUEUES;
				end
			endcase
		end
	end

	// Lowest key wins, ties by rotating start point after last grant
	logic [QW-1:0] sel_q;
	logic sel_ok;
	logic [KW-1:0] sel_key;
	always_comb begin
		logic [QW-1:0] idx;
		idx = '0;
		sel_q = '0;
		sel_ok = 1'b0;
		sel_key = '1;
		for (int i = 0; i < NQ; i++) begin
			idx = QW'((int'(rr_r) + 1 + i) % NQ);
			if (elig[idx] && (!sel_ok || key[idx] < sel_key)) begin
				sel_q = idx;
				sel_ok = 1'b1;
				sel_key = key[idx];
			end
		end
	end
	wire grant_fire = link_ready_i && budget_r != '0 && sel_ok;

	// Ingress classification and drop policy
	logic [QW-1:0] in_q;
	logic [OW:0] in_fill;
	logic drop;
	always_comb begin
		in_q = (pkt_i.rule > DEF_Q) ? DEF_Q : pkt_i.rule;
		if (mode_r == qos_sched_pkg::MODE_DIFFSERV)
			in_q = ds_queue(pkt_i.dscp);
		in_fill = {1'b0, occ_r[in_q]} + {1'b0, pkt_i.len};
		drop = efilt[in_q]
			|| in_fill > CAP
			|| (ewred[in_q] && {1'b0, occ_r[in_q]} >= HALF && lfsr_r[0]);
	end
	wire pkt_take = pkt_valid_i && !drop;

	// Wishbone slave
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire rule_sp = wb_adr_i >= qos_sched_pkg::ADR_RULE_BASE;
	wire [7:0] rq8 = 8'((wb_adr_i - qos_sched_pkg::ADR_RULE_BASE) >> 4);
	wire [QW-1:0] rq = rq8[QW-1:0];
	wire rq_ok = rule_sp && rq8 < 8'(NQ);
	wire [1:0] fld = wb_adr_i[3:2];
	logic [31:0] rd_val;
	logic [31:0] wr_val;
	logic any_occ;
	always_comb begin
		any_occ = 1'b0;
		for (int q = 0; q < NQ; q++)
			any_occ = any_occ | (occ_r[q] != '0);
		rd_val = '0;
		if (rq_ok) begin
			unique case (fld)
				qos_sched_pkg::FLD_CFG: rd_val = 32'({filt_r[rq], wred_r[rq], prio_r[rq]});
				qos_sched_pkg::FLD_MIN: rd_val = 32'(min_r[rq]);
				qos_sched_pkg::FLD_MAX: rd_val = 32'(max_r[rq]);
				qos_sched_pkg::FLD_OCC: rd_val = 32'(occ_r[rq]);
			endcase
		end else if (wb_adr_i == qos_sched_pkg::ADR_MODE) begin
			rd_val = 32'(mode_r);
		end else if (wb_adr_i == qos_sched_pkg::ADR_STATUS) begin
			rd_val = 32'({budget_r, sel_ok, any_occ});
		end else if (wb_adr_i == qos_sched_pkg::ADR_DROPS) begin
			rd_val = drops_r;
		end
		for (int b = 0; b < 4; b++)
			wr_val[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : rd_val[b*8 +: 8];
	end
	// Write lands on the ack edge, while the master still holds every qualifier
	wire wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_val : '0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			mode_r <= qos_sched_pkg::MODE_MAXPRI;
			cfg_chg_r <= 1'b0;
			for (int q = 0; q < NQ; q++) begin
				prio_r[q] <= qos_sched_pkg::PRIO_RST;
				wred_r[q] <= 1'b0;
				filt_r[q] <= 1'b0;
				min_r[q] <= qos_sched_pkg::MIN_RST;
				max_r[q] <= qos_sched_pkg::MAX_RST;
			end
		end else begin
			cfg_chg_r <= wr_en;
			if (wr_en && wb_adr_i == qos_sched_pkg::ADR_MODE && wr_val[1:0] != 2'h3)
				mode_r <= qos_sched_pkg::mode_type'(wr_val[1:0]);
			if (wr_en && rq_ok) begin
				unique case (fld)
					qos_sched_pkg::FLD_CFG: begin
						prio_r[rq] <= wr_val[qos_sched_pkg::CFG_PRIO_LSB +: 4];
						wred_r[rq] <= wr_val[qos_sched_pkg::CFG_WRED_BIT];
						filt_r[rq] <= wr_val[qos_sched_pkg::CFG_FILT_BIT];
					end
					qos_sched_pkg::FLD_MIN: min_r[rq] <= wr_val[RW-1:0];
					qos_sched_pkg::FLD_MAX: max_r[rq] <= wr_val[RW-1:0];
					qos_sched_pkg::FLD_OCC: ;
				endcase
			end
		end
	end

	// Queue fill; a queue can gain and lose in one cycle
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			for (int q = 0; q < NQ; q++)
				occ_r[q] <= '0;
		end else begin
			for (int q = 0; q < NQ; q++)
				occ_r[q] <= occ_r[q] + ((pkt_take && in_q == q) ? pkt_i.len : OW'(0))
					- OW'(grant_fire && sel_q == q);
		end
	end

	// Credits reload each epoch and on any rate or setting change
	wire reload = epoch_r == 16'(qos_sched_pkg::EPOCH_CYCLES - 1)
		|| rate_prev_r != link_rate_i || cfg_chg_r;
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			epoch_r <= '0;
			rate_prev_r <= '0;
			budget_r <= '0;
			for (int q = 0; q < NQ; q++) begin
				min_cred_r[q] <= '0;
				max_cred_r[q] <= '0;
			end
		end else begin
			rate_prev_r <= link_rate_i;
			epoch_r <= reload ? '0 : epoch_r + 16'h0001;
			if (reload)
				budget_r <= link_rate_i;
			else if (grant_fire)
				budget_r <= budget_r - 16'h0001;
			for (int q = 0; q < NQ; q++) begin
				if (reload) begin
					min_cred_r[q] <= min_r[q];
					max_cred_r[q] <= max_r[q];
				end else if (grant_fire && sel_q == q) begin
					if (min_cred_r[q] != '0)
						min_cred_r[q] <= min_cred_r[q] - 16'h0001;
					if (max_cred_r[q] != '0)
						max_cred_r[q] <= max_cred_r[q] - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			rr_r <= DEF_Q;
			grant_valid_o <= 1'b0;
			grant_o <= '0;
		end else begin
			grant_valid_o <= grant_fire;
			if (grant_fire) begin
				rr_r <= sel_q;
				grant_o.queue <= sel_q;
			end
		end
	end

	// Drop reporting; LFSR gives roughly one in two early drops
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			pkt_ready_o <= 1'b0;
			pkt_drop_o <= 1'b0;
			drops_r <= '0;
			lfsr_r <= qos_sched_pkg::LFSR_SEED;
		end else begin
			pkt_ready_o <= 1'b1;
			pkt_drop_o <= pkt_valid_i && drop;
			if (pkt_valid_i && drop)
				drops_r <= drops_r + 32'h1;
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		end
	end

	// Helpers for checks
	logic min_pend;
	logic user_elig;
	logic hi_elig;
	always_comb begin
		min_pend = 1'b0;
		user_elig = 1'b0;
		hi_elig = 1'b0;
		for (int q = 0; q < NUM_RULES; q++) begin
			min_pend = min_pend | (elig[q] && min_cred_r[q] != '0);
			user_elig = user_elig | elig[q];
			hi_elig = hi_elig | (elig[q] && eprio[q] < qos_sched_pkg::PRIO_ASSURED);
		end
	end
	wire sel_af = sel_q >= qos_sched_pkg::DS_AF_FIRST && sel_q <= qos_sched_pkg::DS_AF_LAST;

	property p_mm_prio;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		mode_r == qos_sched_pkg::MODE_MINMAX |-> eprio[DEF_Q] == 4'h9 && eprio[0] == 4'h8;
	endproperty
	a_mm_prio: assert property (p_mm_prio) else $error("minmax priorities wrong");
	property p_min_first;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		grant_fire && mode_r == qos_sched_pkg::MODE_MINMAX && min_cred_r[sel_q] == '0
			|-> !min_pend;
	endproperty
	a_min_first: assert property (p_min_first) else $error("minimum skipped");
	property p_def_last;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		grant_fire && mode_r == qos_sched_pkg::MODE_MINMAX && sel_q == DEF_Q |-> !user_elig;
	endproperty
	a_def_last: assert property (p_def_last) else $error("default served early");
	property p_clip;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		grant_fire && mode_r != qos_sched_pkg::MODE_DIFFSERV |-> max_cred_r[sel_q] != '0;
	endproperty
	a_clip: assert property (p_clip) else $error("served past clipping rate");
	property p_af_after_hi;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		grant_fire && mode_r == qos_sched_pkg::MODE_DIFFSERV && sel_af |-> !hi_elig;
	endproperty
	a_af_after_hi: assert property (p_af_after_hi) else $error("assured before higher");
	property p_tail;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		pkt_take |-> in_fill <= CAP ##1 !pkt_drop_o;
	endproperty
	a_tail: assert property (p_tail) else $error("queue overfilled");
	property p_wred_half;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		pkt_valid_i && !efilt[in_q] && in_fill <= CAP && {1'b0, occ_r[in_q]} < HALF
			|=> !pkt_drop_o;
	endproperty
	a_wred_half: assert property (p_wred_half) else $error("early drop below half fill");
	property p_filter;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		pkt_valid_i && efilt[in_q] |=> pkt_drop_o && occ_r[$past(in_q)] <= $past(occ_r[in_q]);
	endproperty
	a_filter: assert property (p_filter) else $error("filtered packet kept");
	property p_rate;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		rate_prev_r != link_rate_i |=> budget_r == $past(link_rate_i);
	endproperty
	a_rate: assert property (p_rate) else $error("rate change not applied");
	property p_budget;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		budget_r == '0 && !reload |=> !grant_valid_o;
	endproperty
	a_budget: assert property (p_budget) else $error("grant beyond link rate");
	property p_be;
		@(posedge clk_sys_i) disable iff (!reset_n_i)
		mode_r == qos_sched_pkg::MODE_DIFFSERV && pkt_i.dscp == 6'h00
			|-> in_q == qos_sched_pkg::DS_BE_Q;
	endproperty
	a_be: assert property (p_be) else $error("unmatched code point misrouted");
endmodule // qos_scheduler

// [testbench/link_partner.sv]
// Transmit path model: paces link ready, sets the data rate, logs granted queues
`timescale 1ns/100ps
module link_partner (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic en_i,
	input wire logic slow_i,
	input wire logic [15:0] rate_i,
	input wire logic grant_valid_i,
	input wire qos_sched_pkg::grant_type grant_i,
	output logic link_ready_o,
	output logic [15:0] link_rate_o
);
	logic [5:0] seq[$];
	logic phase_r;
	// Slow mode takes a unit only every other cycle
	always @(posedge clk_sys_i) begin
		phase_r <= ~phase_r & reset_n_i;
		link_ready_o <= en_i & reset_n_i & (~slow_i | phase_r);
		link_rate_o <= rate_i;
		if (grant_valid_i === 1'b1) begin
			seq.push_back(grant_i.queue);
		end
	end
	task automatic clear();
		seq.delete();
	endtask
endmodule // link_partner

// [testbench/tb.sv]
// Directed bench: register access, drop policy, grant order and epoch budget
`timescale 1ns/100ps
module tb;
	localparam int QCAP = 64;
	localparam logic [1:0] F_CFG = qos_sched_pkg::FLD_CFG;
	localparam logic [1:0] F_MIN = qos_sched_pkg::FLD_MIN;
	localparam logic [1:0] F_MAX = qos_sched_pkg::FLD_MAX;
	localparam logic [1:0] F_OCC = qos_sched_pkg::FLD_OCC;
	localparam logic [11:0] A_MODE = qos_sched_pkg::ADR_MODE;
	logic clk_sys_i, reset_n_i, wb_cyc, wb_stb, wb_we, wb_ack, pkt_valid, pkt_ready, pkt_drop;
	logic link_ready, link_en, link_slow, grant_valid;
	logic [11:0] wb_adr;
	logic [31:0] wb_wdat, wb_rdat, rv;
	logic [15:0] link_rate, rate_set;
	qos_sched_pkg::pkt_in_type pkt;
	qos_sched_pkg::grant_type grant;
	int err_count, n_tests;
	logic [5:0] exp_q;

	qos_scheduler #(.QUEUE_CAP(QCAP)) uut (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pkt_valid_i(pkt_valid), .pkt_i(pkt),
		.pkt_ready_o(pkt_ready), .pkt_drop_o(pkt_drop), .link_rate_i(link_rate),
		.link_ready_i(link_ready), .grant_valid_o(grant_valid), .grant_o(grant)
	);
	link_partner far (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .en_i(link_en), .slow_i(link_slow),
		.rate_i(rate_set), .grant_valid_i(grant_valid), .grant_i(grant),
		.link_ready_o(link_ready), .link_rate_o(link_rate)
	);

	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	task automatic complete_run();
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_q(input string nm, input logic [5:0] e, input logic [5:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	function automatic logic [11:0] ra(input int q, input logic [1:0] f);
		return qos_sched_pkg::ADR_RULE_BASE + 12'(q * 16) + {8'h00, f, 2'b00};
	endfunction
	task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 40);
		rv = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		chk("wb ack", 32'h1, {31'h0, wb_ack});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rv);
	endtask
	task automatic send(input int r, input logic [5:0] ds, input int len, input logic drop);
		@(posedge clk_sys_i);
		pkt_valid <= 1'b1;
		pkt <= '{rule: 6'(r), dscp: ds, len: 16'(len)};
		@(posedge clk_sys_i);
		pkt_valid <= 1'b0;
		@(posedge clk_sys_i);
		chk("pkt_drop", {31'h0, drop}, {31'h0, pkt_drop});
	endtask
	task automatic wait_n(input int n);
		int k;
		k = 0;
		while (far.seq.size() < n && k < 300) begin
			@(posedge clk_sys_i);
			k++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		$display("[ERR] watchdog expected finish seen timeout");
		err_count++;
		complete_run();
	end

	initial begin
		reset_n_i = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 12'h000;
		wb_wdat = 32'h0;
		pkt_valid = 1'b0;
		pkt = '0;
		link_en = 1'b0;
		link_slow = 1'b0;
		rate_set = 16'h0000;
		err_count = 0;
		n_tests = 0;
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		rd_chk("mode", A_MODE, 32'h0);
		chk("pkt_ready", 32'h1, {31'h0, pkt_ready});
		rd_chk("cfg0", ra(0, F_CFG), 32'h1);
		rd_chk("min32", ra(32, F_MIN), 32'h0);
		rd_chk("max32", ra(32, F_MAX), 32'hffff);
		rd_chk("unmapped", 12'h0f0, 32'h0);
		wr(ra(7, F_CFG), 32'h21);
		wr(ra(8, F_MAX), 32'h0);
		wr(ra(3, F_MAX), 32'h2);
		wr(ra(4, F_CFG), 32'h2);
		send(7, 6'h00, 4, 1'b1);
		send(8, 6'h00, 40, 1'b0);
		send(8, 6'h00, 30, 1'b1);
		rd_chk("occ8", ra(8, F_OCC), 32'd40);
		wr(ra(8, F_OCC), 32'h0);
		rd_chk("occ8 ro", ra(8, F_OCC), 32'd40);
		rd_chk("drops", qos_sched_pkg::ADR_DROPS, 32'h2);
		send(3, 6'h00, 5, 1'b0);
		send(3, 6'h00, 5, 1'b0);
		send(4, 6'h00, 6, 1'b0);
		rd_chk("occ3", ra(3, F_OCC), 32'd10);
		// Budget of one unit: the second grant marks an epoch start, so the
		// following window is free of epoch reloads
		rate_set <= 16'h0001;
		link_en <= 1'b1;
		wait_n(1);
		wait_n(2);
		repeat (150) @(posedge clk_sys_i);
		chk("epoch grants", 32'd2, 32'(far.seq.size()));
		chk_q("sync queue", 6'd3, far.seq[1]);
		far.clear();
		rate_set <= 16'h00ff;
		repeat (40) @(posedge clk_sys_i);
		link_en <= 1'b0;
		chk("window grants", 32'd8, 32'(far.seq.size()));
		for (int i = 0; i < 8; i++) begin
			exp_q = (i < 2) ? 6'd3 : 6'd4;
			chk_q("maxpri order", exp_q, far.seq[i]);
		end
		wr(ra(3, F_MAX), 32'h0);
		wr(ra(5, F_CFG), 32'hf);
		wr(A_MODE, 32'h1);
		send(5, 6'h00, 4, 1'b0);
		send(6, 6'h00, 4, 1'b0);
		send(32, 6'h00, 4, 1'b0);
		far.clear();
		link_slow <= 1'b1;
		link_en <= 1'b1;
		wait_n(12);
		link_en <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			exp_q = (i >= 8) ? 6'd32 : ((i % 2 == 0) ? 6'd5 : 6'd6);
			chk_q("minmax order", exp_q, far.seq[i]);
		end
		wr(A_MODE, 32'h2);
		wr(A_MODE, 32'h3);
		rd_chk("mode kept", A_MODE, 32'h2);
		send(7, 6'b111000, 3, 1'b0);
		send(9, 6'h00, 1, 1'b0);
		rd_chk("occ cs7", ra(0, F_OCC), 32'd3);
		rd_chk("occ be", ra(10, F_OCC), 32'd1);
		far.clear();
		link_slow <= 1'b0;
		link_en <= 1'b1;
		wait_n(9);
		for (int i = 0; i < 9; i++) begin
			exp_q = (i < 3) ? 6'd0 : 6'd3;
			chk_q("diffserv order", exp_q, far.seq[i]);
		end
		complete_run();
	end
endmodule // tb
